// ---- src/stdby_pkg.sv ----
// shared constants for the standby (halt/stop) controller
package stdby_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_SETTLE    = 8'h08;
  // control register fields
  localparam int         CTRL_SIO_EXT   = 0;
  // status register fields
  localparam int         ST_MODE_LSB    = 0;
  localparam int         ST_CPU_CLK     = 4;
  localparam int         ST_OSC_ON      = 5;
  localparam int         ST_XTAL_PU     = 6;
  localparam int         ST_LAST_VEC    = 7;
  // settle select: reset value and largest meaningful code
  localparam logic [7:0] SETTLE_SEL_RST = 8'h04;
  localparam logic [7:0] SETTLE_SEL_MAX = 8'h04;
  localparam int         SETTLE_CNT_W   = 20;
  // wake latency in clocks, lower edge of each allowed window
  localparam logic [3:0] WAKE_VEC_CLKS  = 4'h8;
  localparam logic [3:0] WAKE_RES_CLKS  = 4'h2;
  // controller modes
  typedef enum logic [2:0] {
    MODE_RUN    = 3'b000,
    MODE_HALT   = 3'b001,
    MODE_STOP   = 3'b010,
    MODE_SETTLE = 3'b011,
    MODE_WAKE   = 3'b100
  } mode_t;
endpackage

// ---- src/settle_timer.sv ----
// oscillation settle down-counter with a one-cycle done pulse
`timescale 1ns/1ps
module settle_timer
  import stdby_pkg::*;
#(
  parameter int W = SETTLE_CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_i,
  output logic              done_o
);
  typedef struct packed {
    logic         busy;
    logic [W-1:0] cnt;
    logic         done;
  } tmr_t;

  tmr_t s_r;
  tmr_t s_nxt;

  // count down the loaded number of cycles, pulse done at the end
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start_i) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = load_i;
    end else if (s_r.busy) begin
      if (s_r.cnt <= W'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_o = s_r.done;
endmodule

// ---- src/standby_ctrl.sv ----
// standby controller: light sleep, deep sleep, settle wait and wake-up
// Functional notes
// - A light-sleep instruction gates the cpu clock but keeps the oscillator.
// - In any sleep mode the port output latches hold their previous values.
// - In light sleep timers, watchdog, adc and serial run; display is off.
// - An unmasked request ends light sleep, vectored if acknowledge is on.
// - Light-sleep wake takes 8 clocks if vectored and 2 clocks if resuming.
// - A non-maskable request always ends light sleep with vectored service.
// - Reset during sleep returns to run and normal reset processing.
// - A low-priority wake is vectored only with acknowledge and in-service.
// - A deep-sleep instruction stops both the oscillator and the cpu clock.
// - Deep sleep pulls the crystal output pin up to the supply.
// - Deep sleep with a request already pending falls to the settle wait.
// - In deep sleep latches hold and timers, watchdog, adc and display stop.
// - Serial runs in deep sleep only when set to an external shift clock.
// - External interrupt detection stays active in every mode.
// - An unmasked request ends deep sleep; after settling it is serviced.
// - The settle select register resets to 04H, a wait of 2^16 clocks.
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module standby_ctrl
  import stdby_pkg::*;
#(
  parameter int N_IRQ       = 16,
  parameter int SETTLE_EXP0 = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  // cpu core
  input  wire logic             halt_exec_i,
  input  wire logic             stop_exec_i,
  input  wire logic             interrupt_ack_enable_i,
  input  wire logic             in_service_priority_flag_i,
  // interrupt controller flags
  input  wire logic [N_IRQ-1:0] int_req_i,
  input  wire logic [N_IRQ-1:0] interrupt_mask_flag_i,
  input  wire logic [N_IRQ-1:0] priority_low_flag_i,
  input  wire logic             nmi_req_i,
  // clock and wake controls
  output logic                  cpu_clk_en_o,
  output logic                  osc_en_o,
  output logic                  crystal_output_pin_pullup_o,
  output logic                  port_latch_hold_o,
  output logic                  wake_vector_o,
  output logic                  wake_resume_o,
  // peripheral run enables
  output logic                  rmt_timer_en_o,
  output logic                  pwm_timer_en_o,
  output logic                  watchdog_en_o,
  output logic                  adc_en_o,
  output logic                  serial_en_o,
  output logic                  display_en_o,
  output logic                  ext_int_detect_en_o
);
  typedef struct packed {
    mode_t       mode;
    logic [3:0]  lat;
    logic        vec;
    logic        last_vec;
    logic [7:0]  settle_sel;
    logic        sio_ext;
    logic        ack;
    logic [31:0] dat;
    logic        cpu_clk;
    logic        osc;
    logic        xtal_pu;
    logic        hold;
    logic        wake_vec;
    logic        wake_res;
    logic        settle_go;
    logic        rmt;
    logic        pwm;
    logic        wdt;
    logic        adc;
    logic        sio;
    logic        disp;
  } ctl_t;

  ctl_t s_r;
  ctl_t s_nxt;

  logic                    settle_done;
  logic                    wake_any;
  logic                    wake_vec_now;
  logic [N_IRQ-1:0]        unmasked;
  logic [SETTLE_CNT_W-1:0] settle_load;
  logic                    wb_req;

  // any unmasked maskable request
  function automatic logic pending_any(input logic [N_IRQ-1:0] req,
                                       input logic [N_IRQ-1:0] msk);
    return |(req & ~msk);
  endfunction

  // settle length from the select code, clipped at the top code
  function automatic logic [SETTLE_CNT_W-1:0] settle_cycles(
      input logic [7:0] sel);
    logic [7:0]              code;
    logic [SETTLE_CNT_W-1:0] one;
    code = (sel > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : sel;
    one  = SETTLE_CNT_W'(1);
    return one << (SETTLE_EXP0 + int'(code));
  endfunction

  // wake decision from masks, priorities and cpu flags
  always_comb begin
    unmasked     = int_req_i & ~interrupt_mask_flag_i;
    wake_any     = nmi_req_i
                   | pending_any(int_req_i, interrupt_mask_flag_i);
    wake_vec_now = nmi_req_i
                   | (interrupt_ack_enable_i
                      & |(unmasked & ~priority_low_flag_i))
                   | (interrupt_ack_enable_i
                      & in_service_priority_flag_i
                      & |(unmasked & priority_low_flag_i));
    settle_load  = settle_cycles(s_r.settle_sel);
    wb_req       = wb_cyc_i & wb_stb_i;
  end

  // mode machine, register file and derived output levels
  always_comb begin
    s_nxt           = s_r;
    s_nxt.wake_vec  = 1'b0;
    s_nxt.wake_res  = 1'b0;
    s_nxt.settle_go = 1'b0;
    unique case (s_r.mode)
      MODE_RUN: begin
        if (stop_exec_i && wake_any) begin
          s_nxt.mode      = MODE_SETTLE;
          s_nxt.vec       = wake_vec_now;
          s_nxt.settle_go = 1'b1;
        end else if (stop_exec_i) begin
          s_nxt.mode = MODE_STOP;
        end else if (halt_exec_i) begin
          s_nxt.mode = MODE_HALT;
        end
      end
      MODE_HALT: begin
        // masked requests keep the machine here; only unmasked or non-maskable ones leave
        if (wake_any) begin
          s_nxt.mode = MODE_WAKE;
          s_nxt.vec  = wake_vec_now;
          s_nxt.lat  = (wake_vec_now ? WAKE_VEC_CLKS
                                     : WAKE_RES_CLKS) - 4'h1;
        end
      end
      MODE_STOP: begin
        if (wake_any) begin
          s_nxt.mode      = MODE_SETTLE;
          s_nxt.vec       = wake_vec_now;
          s_nxt.settle_go = 1'b1;
        end
      end
      MODE_SETTLE: begin
        // the cpu is released only after the full settle count
        if (settle_done) begin
          s_nxt.mode = MODE_WAKE;
          s_nxt.lat  = (s_r.vec ? WAKE_VEC_CLKS
                                : WAKE_RES_CLKS) - 4'h1;
        end
      end
      MODE_WAKE: begin
        if (s_r.lat <= 4'h1) begin
          s_nxt.mode     = MODE_RUN;
          s_nxt.wake_vec = s_r.vec;
          s_nxt.wake_res = ~s_r.vec;
          s_nxt.last_vec = s_r.vec;
        end
        s_nxt.lat = s_r.lat - 4'h1;
      end
      default: begin
        s_nxt.mode = MODE_RUN;
      end
    endcase

    // clock gating and pin control follow the next mode
    s_nxt.cpu_clk = (s_nxt.mode == MODE_RUN);
    s_nxt.osc     = (s_nxt.mode != MODE_STOP);
    s_nxt.xtal_pu = (s_nxt.mode == MODE_STOP);
    s_nxt.hold    = (s_nxt.mode != MODE_RUN);
    // peripherals: run all, halt all but display, deep sleep serial only
    unique case (s_nxt.mode)
      MODE_RUN: begin
        {s_nxt.rmt, s_nxt.pwm, s_nxt.wdt, s_nxt.adc} = 4'hF;
        s_nxt.sio  = 1'b1;
        s_nxt.disp = 1'b1;
      end
      MODE_HALT, MODE_WAKE: begin
        {s_nxt.rmt, s_nxt.pwm, s_nxt.wdt, s_nxt.adc} = 4'hF;
        s_nxt.sio  = 1'b1;
        s_nxt.disp = 1'b0;
      end
      default: begin
        {s_nxt.rmt, s_nxt.pwm, s_nxt.wdt, s_nxt.adc} = 4'h0;
        s_nxt.sio  = s_r.sio_ext;
        s_nxt.disp = 1'b0;
      end
    endcase

    // wishbone: ack one cycle after the request, write on the ack edge
    s_nxt.ack = wb_req & ~s_r.ack;
    if (wb_req && !s_r.ack) begin
      unique case (wb_adr_i)
        ADDR_CTRL:   s_nxt.dat = {31'h0, s_r.sio_ext};
        ADDR_STATUS: s_nxt.dat = {24'h0, s_r.last_vec, s_r.xtal_pu,
                                  s_r.osc, s_r.cpu_clk, 1'b0, s_r.mode};
        ADDR_SETTLE: s_nxt.dat = {24'h0, s_r.settle_sel};
        default:     s_nxt.dat = 32'h0;
      endcase
    end
    if (wb_req && s_r.ack && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_CTRL) begin
        s_nxt.sio_ext = wb_dat_i[CTRL_SIO_EXT];
      end
      if (wb_adr_i == ADDR_SETTLE) begin
        s_nxt.settle_sel = wb_dat_i[7:0];
      end
    end
  end

  // register stage; reset gives run mode with all clocks on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r            <= '0;
      s_r.mode       <= MODE_RUN;
      s_r.settle_sel <= SETTLE_SEL_RST;
      s_r.cpu_clk    <= 1'b1;
      s_r.osc        <= 1'b1;
      s_r.rmt        <= 1'b1;
      s_r.pwm        <= 1'b1;
      s_r.wdt        <= 1'b1;
      s_r.adc        <= 1'b1;
      s_r.sio        <= 1'b1;
      s_r.disp       <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // settle wait counter
  settle_timer #(
    .W       (SETTLE_CNT_W)
  ) u_settle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (s_r.settle_go),
    .load_i  (settle_load),
    .done_o  (settle_done)
  );

  // outputs straight from flops; external detection never switched off
  assign wb_dat_o                    = s_r.dat;
  assign wb_ack_o                    = s_r.ack;
  assign cpu_clk_en_o                = s_r.cpu_clk;
  assign osc_en_o                    = s_r.osc;
  assign crystal_output_pin_pullup_o = s_r.xtal_pu;
  assign port_latch_hold_o           = s_r.hold;
  assign wake_vector_o               = s_r.wake_vec;
  assign wake_resume_o               = s_r.wake_res;
  assign rmt_timer_en_o              = s_r.rmt;
  assign pwm_timer_en_o              = s_r.pwm;
  assign watchdog_en_o               = s_r.wdt;
  assign adc_en_o                    = s_r.adc;
  assign serial_en_o                 = s_r.sio;
  assign display_en_o                = s_r.disp;
  assign ext_int_detect_en_o         = 1'b1;

  // light sleep: cpu clock off, oscillator on
  chk_halt_clock_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT) |-> (!cpu_clk_en_o && osc_en_o))
    else $error("light sleep clock gating wrong");

  // latch hold on the first cycle after leaving run mode
  chk_port_hold_sleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(s_r.mode != MODE_RUN) |-> port_latch_hold_o
      throughout (s_r.mode != MODE_RUN)[*1])
    else $error("port hold missing in sleep");

  // light sleep peripheral set
  chk_halt_periph_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT) |-> (rmt_timer_en_o && pwm_timer_en_o
      && watchdog_en_o && adc_en_o && serial_en_o && !display_en_o))
    else $error("light sleep peripheral enables wrong");

  // masked requests keep light sleep
  chk_masked_keep_halt: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT && !wake_any) |=> (s_r.mode == MODE_HALT))
    else $error("light sleep left without unmasked request");

  // vectored wake after eight clocks
  chk_vec_wake_latency: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT && wake_any && wake_vec_now)
      |-> !wake_vector_o [*8] ##1 wake_vector_o)
    else $error("vectored wake latency not 8 clocks");

  // non-maskable request ignores acknowledge enable
  chk_nmi_always_vec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT && nmi_req_i && !interrupt_ack_enable_i)
      |-> ##8 (wake_vector_o && !wake_resume_o))
    else $error("nmi wake not vectored");

  // reset release lands in run mode
  chk_reset_to_run: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (s_r.mode == MODE_RUN && cpu_clk_en_o))
    else $error("reset did not return to run");

  // low priority wake resumes unless ack and in-service both set
  chk_lowpri_resume: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_HALT && !nmi_req_i
      && !(|(unmasked & ~priority_low_flag_i))
      && |(unmasked & priority_low_flag_i)
      && !(interrupt_ack_enable_i && in_service_priority_flag_i))
      |-> ##2 wake_resume_o)
    else $error("low priority wake not resumed in 2 clocks");

  // deep sleep: oscillator and cpu stopped, crystal pin pulled up
  chk_stop_osc_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_STOP) |-> (!osc_en_o && !cpu_clk_en_o
      && crystal_output_pin_pullup_o))
    else $error("deep sleep clocks or pull-up wrong");

  // pending request turns deep sleep into the settle wait
  chk_stop_pending_fall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_RUN && stop_exec_i && wake_any)
      |=> (s_r.mode == MODE_SETTLE && osc_en_o))
    else $error("pending request did not skip deep sleep");

  // deep sleep peripheral set
  chk_stop_periph_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_STOP) |-> (!rmt_timer_en_o && !pwm_timer_en_o
      && !watchdog_en_o && !adc_en_o && !display_en_o
      && serial_en_o == s_r.sio_ext))
    else $error("deep sleep peripheral enables wrong");

  // settle state is left only on the counter
  chk_settle_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_SETTLE && !settle_done)
      |=> (s_r.mode == MODE_SETTLE))
    else $error("settle wait left early");

  // settle end moves to wake, then service
  chk_settle_to_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MODE_SETTLE && settle_done && s_r.vec)
      |=> (s_r.mode == MODE_WAKE) ##7 wake_vector_o)
    else $error("deep sleep release sequence wrong");

  // settle select comes out of reset at its default
  chk_settle_sel_rst: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (s_r.settle_sel == SETTLE_SEL_RST))
    else $error("settle select reset value wrong");
endmodule

// ---- verification/cpu_irq_model.sv ----
// cpu core and interrupt controller stand-in for the standby bench
`timescale 1ns/1ps
module cpu_irq_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        halt_cmd_i,
  input  wire logic        stop_cmd_i,
  input  wire logic        cpu_clk_en_i,
  input  wire logic        req_on_i,
  input  wire logic [3:0]  req_idx_i,
  input  wire logic        nmi_on_i,
  input  wire logic        wake_vector_i,
  output logic             halt_exec_o,
  output logic             stop_exec_o,
  output logic [15:0]      int_req_o,
  output logic             nmi_req_o
);
  logic served_r;
  // a gated cpu fetches nothing, so it cannot issue a sleep instruction
  assign halt_exec_o = halt_cmd_i & cpu_clk_en_i;
  assign stop_exec_o = stop_cmd_i & cpu_clk_en_i;
  // vectored service clears the flag until the source lets go
  always_ff @(posedge clk_i) begin
    if (rst_i || !(req_on_i || nmi_on_i)) served_r <= 1'b0;
    else if (wake_vector_i) served_r <= 1'b1;
  end
  // one source at a time keeps the wake decision unambiguous
  assign int_req_o = (req_on_i && !served_r) ? 16'h0001 << req_idx_i
                                             : 16'h0000;
  assign nmi_req_o = nmi_on_i & !served_r;
endmodule

// ---- verification/tb_standby_ctrl.sv ----
// self-checking bench for the standby controller
`timescale 1ns/1ps
module tb_standby_ctrl;
  import stdby_pkg::*;
  localparam int EXP0 = 2;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, idx = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        halt_cmd = 0, stop_cmd = 0, req_on = 0, nmi_on = 0;
  logic        ack_en = 0, in_svc = 0, halt_x, stop_x, nmi, vec, res;
  logic [15:0] mask = 16'hFFFF, low = 16'hFFFF, req;
  logic        cpu_en, osc_en, pu, hold, rmt, pwm, wdt, adc, ser, disp, ext;
  logic [10:0] outs;
  int          bad_count = 0, num_checks = 0, cycles = 0;
  assign outs = {cpu_en, osc_en, pu, hold, rmt, pwm, wdt, adc, ser, disp, ext};
  always #12.5 clk_i = ~clk_i;

  standby_ctrl #(.N_IRQ(16), .SETTLE_EXP0(EXP0)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .halt_exec_i(halt_x),
    .stop_exec_i(stop_x), .interrupt_ack_enable_i(ack_en),
    .in_service_priority_flag_i(in_svc), .int_req_i(req),
    .interrupt_mask_flag_i(mask), .priority_low_flag_i(low),
    .nmi_req_i(nmi), .cpu_clk_en_o(cpu_en), .osc_en_o(osc_en),
    .crystal_output_pin_pullup_o(pu), .port_latch_hold_o(hold),
    .wake_vector_o(vec), .wake_resume_o(res), .rmt_timer_en_o(rmt),
    .pwm_timer_en_o(pwm), .watchdog_en_o(wdt), .adc_en_o(adc),
    .serial_en_o(ser), .display_en_o(disp), .ext_int_detect_en_o(ext));

  cpu_irq_model partner (
    .clk_i(clk_i), .rst_i(rst_i), .halt_cmd_i(halt_cmd),
    .stop_cmd_i(stop_cmd), .cpu_clk_en_i(cpu_en), .req_on_i(req_on),
    .req_idx_i(idx), .nmi_on_i(nmi_on), .wake_vector_i(vec),
    .halt_exec_o(halt_x), .stop_exec_o(stop_x), .int_req_o(req),
    .nmi_req_o(nmi));

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask

  // one classic cycle; held until ack, released at the edge that sees it
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // ack and data are taken at the very edge that samples ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    check("wb_ack_lat", n, 32'h2);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(nm, q, e);
  endtask

  task automatic sleep(input logic deep);
    @(posedge clk_i);
    if (deep) stop_cmd <= 1'b1;
    else halt_cmd <= 1'b1;
    @(posedge clk_i);
    stop_cmd <= 1'b0;
    halt_cmd <= 1'b0;
    #1;
  endtask

  // edges from the causing edge until a wake pulse shows
  task automatic wait_wake(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (vec !== 1'b1 && res !== 1'b1 && n < lim);
  endtask

  // {cpu,osc,pullup,hold,rmt,pwm,wdt,adc,serial,display,ext}
  function automatic logic [10:0] exp_outs(input int m, input logic sx);
    if (m == 1) return 11'b01011111101;
    if (m == 2) return {8'b00110000, sx, 2'b01};
    return 11'b11001111111;
  endfunction

  function automatic logic exp_vec(input logic n, e, s, l);
    return n | (e & (!l | s));
  endfunction

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    logic [31:0] q;
    int n, k, cnt;
    logic e, s, l, v, sx, pend;
    logic [7:0] sv;
    void'($urandom(32'hF020));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 check("rst_outs", outs, exp_outs(0, 1'b0));
    rd_chk("settle_rst", ADDR_SETTLE, 32'h04);
    rd_chk("ctrl_rst", ADDR_CTRL, 32'h0);
    rd_chk("status_rst", ADDR_STATUS, 32'h30);
    wb(1'b1, 8'h0C, 32'hFF, 4'hF, q);
    rd_chk("unmapped", 8'h0C, 32'h0);
    wb(1'b1, ADDR_SETTLE, 32'h01, 4'h0, q);
    rd_chk("sel_lane", ADDR_SETTLE, 32'h04);
    // random light-sleep wakes, every other one masked at first
    for (int i = 0; i < 12; i++) begin
      k = $urandom_range(15);
      e = $urandom_range(1);
      s = $urandom_range(1);
      l = $urandom_range(1);
      sleep(1'b0);
      check("halt_outs", outs, exp_outs(1, 1'b0));
      @(posedge clk_i);
      idx <= k[3:0];
      ack_en <= e;
      in_svc <= s;
      low <= {16{l}};
      req_on <= 1'b1;
      mask <= i[0] ? 16'hFFFF : ~(16'h0001 << k);
      if (i[0]) begin
        repeat (10) @(posedge clk_i);
        #1 check("masked", {vec, res, cpu_en}, 3'b000);
        @(posedge clk_i);
        mask <= ~(16'h0001 << k);
      end
      wait_wake(20, n);
      v = exp_vec(1'b0, e, s, l);
      check("wake_kind", {vec, res}, {v, !v});
      check("wake_lat", n, v ? WAKE_VEC_CLKS : WAKE_RES_CLKS);
      check("run_outs", outs, exp_outs(0, 1'b0));
      @(posedge clk_i);
      req_on <= 1'b0;
      mask <= 16'hFFFF;
    end
    // non-maskable wake with acknowledge off
    sleep(1'b0);
    @(posedge clk_i);
    ack_en <= 1'b0;
    nmi_on <= 1'b1;
    wait_wake(20, n);
    check("nmi_kind", {vec, res}, 2'b10);
    check("nmi_lat", n, WAKE_VEC_CLKS);
    @(posedge clk_i);
    nmi_on <= 1'b0;
    // reset while in light sleep
    sleep(1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1 check("rst_halt", outs, exp_outs(0, 1'b0));
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("rst_mode", ADDR_STATUS, 32'h30);
    // deep sleep: serial clock source, settle codes, pending request
    for (int j = 0; j < 4; j++) begin
      sx = j[0];
      sv = j[1] ? 8'h07 : 8'($urandom_range(3));
      pend = (j == 2);
      wb(1'b1, ADDR_CTRL, {31'h0, sx}, 4'h1, q);
      wb(1'b1, ADDR_SETTLE, {24'h0, sv}, 4'h1, q);
      k = $urandom_range(15);
      e = $urandom_range(1);
      @(posedge clk_i);
      idx <= k[3:0];
      ack_en <= e;
      low <= 16'h0000;
      mask <= ~(16'h0001 << k);
      req_on <= pend;
      sleep(1'b1);
      if (pend) begin
        check("pend_osc", {osc_en, cpu_en}, 2'b10);
      end else begin
        check("stop_outs", outs, exp_outs(2, sx));
        @(posedge clk_i);
        req_on <= 1'b1;
      end
      wait_wake(1000, n);
      cnt = 1 << (EXP0 + ((sv > SETTLE_SEL_MAX) ? 4 : sv));
      check("stop_kind", {vec, res}, {e, !e});
      check("settle_min", n > cnt, 1'b1);
      check("settle_max", n <= cnt + (e ? 8 : 2) + 6, 1'b1);
      @(posedge clk_i);
      req_on <= 1'b0;
    end
    // status keeps the kind of the last wake
    rd_chk("status_vec", ADDR_STATUS, {24'h0, e, 7'h30});
    close_out();
  end
endmodule
